// >>> rtl/tcc_ctrl.v
// Notes on behaviour
// - Compare action per mode/level: none, toggle, low, high
// - Mode or level set makes pin an output
// - Pin disconnect bit blocks compare output driving
// - Edge select: off, rising, falling, both
// - Channel irq when flag and enable set
// - Overflow enable gates overflow flag request
// - New prescale applies when prescaler counter zero
// - Capture or compare match sets channel flag
// - Write one clears channel flag, timer enabled
// - Writing zero leaves flags unchanged
// - Fast clear: value register access clears flag
// - Fast clear: counter access clears overflow flag
// - Counter wrap sets overflow flag
// - Write one bit 7 clears overflow, enabled
// - Unimplemented channel bits ignore writes, read zero
// - Timer enable bit stops or runs timer
// - Precision mode uses eight-bit divisor instead
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tcc_regs.vh"
`default_nettype none

module tcc_ctrl (
  input  wire        clock,
  input  wire        reset_n,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Timer neighbours, same clock
  input  wire        counter_wrap,
  input  wire        counter_access,
  input  wire [3:0]  compare_match,
  input  wire [3:0]  channel_is_compare,
  input  wire [3:0]  value_read,
  input  wire [3:0]  value_write,
  input  wire [3:0]  pin_disconnect_bit,
  input  wire [7:0]  precision_divisor,
  // Channel pins
  input  wire [3:0]  channel_pin_in,
  output reg  [3:0]  compare_output,
  output reg  [3:0]  channel_pin_oe,
  // Timer status to neighbours
  output reg         timer_run,
  output reg         prescale_tick,
  output reg  [3:0]  capture_event,
  output reg  [3:0]  channel_irq,
  output reg         overflow_irq
);

  //////////////////////////////////////////////////////////////////////////
  // Reset release

  reg        rst_meta_n;
  reg        rst_n;

  // Two stages so release never lands near a clock edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  reg        timer_enable_bit;
  reg        fast_flag_clear;
  reg        precision_prescale_mode;
  reg        prec_mode_locked;
  reg  [3:0] out_mode_bit;
  reg  [3:0] out_level_bit;
  reg  [3:0] edge_sel_high;
  reg  [3:0] edge_sel_low;
  reg  [3:0] channel_irq_enable_bits;
  reg        overflow_irq_enable;
  reg  [2:0] prescale_select;
  reg  [3:0] channel_event_flag;
  reg        overflow_flag;

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  reg  [5:0] aw_idx;
  reg        aw_held;
  reg  [7:0] w_byte;
  reg        w_lane0;
  reg        w_held;
  wire       do_write;
  wire [7:0] wr_data;
  reg        wr_mapped;

  // Address and data may arrive in either order; each is parked
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  // A cleared lane 0 strobe writes nothing, since registers are a byte
  assign wr_data  = w_byte;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      aw_idx        <= 6'h00;
      w_held        <= 1'b0;
      w_byte        <= `TCC_RST_BYTE;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TCC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[`TCC_IDX_MSB:`TCC_IDX_LSB];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write decode
  always @* begin
    if (aw_idx == `TCC_IDX_SYS_CTRL_ONE)
      wr_mapped = 1'b1;
    else if (aw_idx >= `TCC_IDX_OUT_ACT_HI && aw_idx <= `TCC_IDX_OVF_FLAG)
      wr_mapped = 1'b1;
    else
      wr_mapped = 1'b0;
  end

  wire wr_en = do_write && w_lane0;
  wire wr_sys = wr_en && (aw_idx == `TCC_IDX_SYS_CTRL_ONE);
  wire wr_act = wr_en && (aw_idx == `TCC_IDX_OUT_ACT_LO);
  wire wr_edg = wr_en && (aw_idx == `TCC_IDX_EDGE_LO);
  wire wr_ien = wr_en && (aw_idx == `TCC_IDX_CH_IRQ_EN);
  wire wr_psc = wr_en && (aw_idx == `TCC_IDX_PRESC_OVF);
  wire wr_cfl = wr_en && (aw_idx == `TCC_IDX_CH_FLAGS);
  wire wr_ofl = wr_en && (aw_idx == `TCC_IDX_OVF_FLAG);

  //////////////////////////////////////////////////////////////////////////
  // Control registers; high halves hold no channels and stay zero

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_enable_bit        <= 1'b0;
      fast_flag_clear         <= 1'b0;
      precision_prescale_mode <= 1'b0;
      prec_mode_locked        <= 1'b0;
      out_mode_bit            <= `TCC_RST_NIBBLE;
      out_level_bit           <= `TCC_RST_NIBBLE;
      edge_sel_high           <= `TCC_RST_NIBBLE;
      edge_sel_low            <= `TCC_RST_NIBBLE;
      channel_irq_enable_bits <= `TCC_RST_NIBBLE;
      overflow_irq_enable     <= 1'b0;
      prescale_select         <= `TCC_RST_PRESC;
    end else begin
      if (wr_sys) begin
        timer_enable_bit <= wr_data[`TCC_BIT_TIMER_EN];
        fast_flag_clear  <= wr_data[`TCC_BIT_FAST_CLR];
        // Precision mode may be written once after reset only
        if (!prec_mode_locked) begin
          precision_prescale_mode <= wr_data[`TCC_BIT_PREC_MODE];
          prec_mode_locked        <= 1'b1;
        end
      end
      if (wr_act) begin
        out_mode_bit  <= {wr_data[7], wr_data[5], wr_data[3], wr_data[1]};
        out_level_bit <= {wr_data[6], wr_data[4], wr_data[2], wr_data[0]};
      end
      if (wr_edg) begin
        edge_sel_high <= {wr_data[7], wr_data[5], wr_data[3], wr_data[1]};
        edge_sel_low  <= {wr_data[6], wr_data[4], wr_data[2], wr_data[0]};
      end
      if (wr_ien)
        channel_irq_enable_bits <= wr_data[3:0];
      if (wr_psc) begin
        overflow_irq_enable <= wr_data[`TCC_BIT_OVF_IRQ_EN];
        prescale_select     <= wr_data[`TCC_PRESC_MSB:`TCC_PRESC_LSB];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler

  reg  [7:0] presc_count;
  reg  [7:0] presc_active;
  reg  [7:0] presc_wanted;

  // Divisor minus one: legacy power of two or precision value
  always @* begin
    if (precision_prescale_mode)
      presc_wanted = precision_divisor;
    else
      presc_wanted = (`TCC_DIV_ONE << prescale_select) - `TCC_DIV_ONE;
  end

  // A new divisor is only picked up on the zero boundary so no
  // shortened or stretched period appears mid-count
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      presc_count   <= `TCC_RST_DIV;
      presc_active  <= `TCC_RST_DIV;
      prescale_tick <= 1'b0;
      timer_run     <= 1'b0;
    end else begin
      timer_run <= timer_enable_bit;
      if (!timer_enable_bit) begin
        presc_count   <= `TCC_RST_DIV;
        presc_active  <= presc_wanted;
        prescale_tick <= 1'b0;
      end else if (presc_count >= presc_active) begin
        presc_count   <= `TCC_RST_DIV;
        presc_active  <= presc_wanted;
        prescale_tick <= 1'b1;
      end else begin
        presc_count   <= presc_count + `TCC_DIV_ONE;
        prescale_tick <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Channels: pin sync, edge detect, compare action, flags

  wire [3:0] flag_set;
  wire [3:0] flag_clr;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      reg  pin_s1;
      reg  pin_s2;
      reg  pin_s3;
      reg  pin_level;
      wire pin_agree;
      wire rise;
      wire fall;
      wire capture;

      // Three stages; a change counts once stages two and three agree
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1    <= 1'b0;
          pin_s2    <= 1'b0;
          pin_s3    <= 1'b0;
          pin_level <= 1'b0;
        end else begin
          pin_s1 <= channel_pin_in[ch];
          pin_s2 <= pin_s1;
          pin_s3 <= pin_s2;
          if (pin_agree)
            pin_level <= pin_s3;
        end
      end

      assign pin_agree = (pin_s2 == pin_s3);
      assign rise      = pin_agree && pin_s3 && !pin_level;
      assign fall      = pin_agree && !pin_s3 && pin_level;
      // Edge select picks which transitions capture
      assign capture   = !channel_is_compare[ch] &&
                         ((edge_sel_low[ch] && rise) ||
                          (edge_sel_high[ch] && fall));

      // Compare action on a match
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          compare_output[ch] <= 1'b0;
          channel_pin_oe[ch] <= 1'b0;
          capture_event[ch]  <= 1'b0;
        end else begin
          capture_event[ch] <= capture;
          // Disconnect wins so the pin is left to other logic
          channel_pin_oe[ch] <= (out_mode_bit[ch] || out_level_bit[ch])
                                && !pin_disconnect_bit[ch];
          if (compare_match[ch] && channel_is_compare[ch]) begin
            case ({out_mode_bit[ch], out_level_bit[ch]})
              `TCC_ACT_TOGGLE: compare_output[ch] <= !compare_output[ch];
              `TCC_ACT_LOW:    compare_output[ch] <= 1'b0;
              `TCC_ACT_HIGH:   compare_output[ch] <= 1'b1;
              default:         compare_output[ch] <= compare_output[ch];
            endcase
          end
        end
      end

      // Flag still sets when disconnected; only the pin is cut
      assign flag_set[ch] = capture ||
             (compare_match[ch] && channel_is_compare[ch]);
      assign flag_clr[ch] =
             (wr_cfl && wr_data[ch] && timer_enable_bit) ||
             (fast_flag_clear &&
              ((value_read[ch] && !channel_is_compare[ch]) ||
               (value_write[ch] && channel_is_compare[ch])));
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Event flags and interrupt requests

  wire ovf_clr = (wr_ofl && wr_data[`TCC_BIT_OVF_FLAG] &&
                  timer_enable_bit) ||
                 (fast_flag_clear && counter_access);

  // Set is applied after clear so a same-cycle event survives
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel_event_flag <= `TCC_RST_NIBBLE;
      overflow_flag      <= 1'b0;
      channel_irq        <= `TCC_RST_NIBBLE;
      overflow_irq       <= 1'b0;
    end else begin
      channel_event_flag <= (channel_event_flag & ~flag_clr) |
                            flag_set;
      overflow_flag      <= (overflow_flag && !ovf_clr) ||
                            counter_wrap;
      channel_irq        <= channel_event_flag &
                            channel_irq_enable_bits;
      overflow_irq       <= overflow_flag && overflow_irq_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  reg  [7:0] rd_byte;
  reg        rd_mapped;
  wire [5:0] ar_idx = s_axi_araddr[`TCC_IDX_MSB:`TCC_IDX_LSB];

  // Read decode; unused channel bits read zero
  always @* begin
    rd_byte   = `TCC_RST_BYTE;
    rd_mapped = 1'b1;
    if (ar_idx == `TCC_IDX_SYS_CTRL_ONE)
      rd_byte = {timer_enable_bit, 2'b00, fast_flag_clear,
                 precision_prescale_mode, 3'b000};
    else if (ar_idx == `TCC_IDX_OUT_ACT_HI)
      rd_byte = `TCC_RST_BYTE;
    else if (ar_idx == `TCC_IDX_OUT_ACT_LO)
      rd_byte = {out_mode_bit[3], out_level_bit[3],
                 out_mode_bit[2], out_level_bit[2],
                 out_mode_bit[1], out_level_bit[1],
                 out_mode_bit[0], out_level_bit[0]};
    else if (ar_idx == `TCC_IDX_EDGE_HI)
      rd_byte = `TCC_RST_BYTE;
    else if (ar_idx == `TCC_IDX_EDGE_LO)
      rd_byte = {edge_sel_high[3], edge_sel_low[3],
                 edge_sel_high[2], edge_sel_low[2],
                 edge_sel_high[1], edge_sel_low[1],
                 edge_sel_high[0], edge_sel_low[0]};
    else if (ar_idx == `TCC_IDX_CH_IRQ_EN)
      rd_byte = {4'h0, channel_irq_enable_bits};
    else if (ar_idx == `TCC_IDX_PRESC_OVF)
      rd_byte = {overflow_irq_enable, 4'h0, prescale_select};
    else if (ar_idx == `TCC_IDX_CH_FLAGS)
      rd_byte = {4'h0, channel_event_flag};
    else if (ar_idx == `TCC_IDX_OVF_FLAG)
      rd_byte = {overflow_flag, 7'h00};
    else
      rd_mapped = 1'b0;
  end

  // One read at a time; arready drops while an answer is pending
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `TCC_ZERO_WORD;
      s_axi_rresp   <= `TCC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {`TCC_ZERO_24, rd_byte};
        s_axi_rresp   <= rd_mapped ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid  <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/tcc_regs.vh
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// Register indexes; byte address is four times the index
`define TCC_IDX_SYS_CTRL_ONE   6'h06
`define TCC_IDX_OUT_ACT_HI     6'h08
`define TCC_IDX_OUT_ACT_LO     6'h09
`define TCC_IDX_EDGE_HI        6'h0a
`define TCC_IDX_EDGE_LO        6'h0b
`define TCC_IDX_CH_IRQ_EN      6'h0c
`define TCC_IDX_PRESC_OVF      6'h0d
`define TCC_IDX_CH_FLAGS       6'h0e
`define TCC_IDX_OVF_FLAG       6'h0f

// Address split
`define TCC_ADDR_W             8
`define TCC_IDX_MSB            7
`define TCC_IDX_LSB            2

// Field positions
`define TCC_BIT_TIMER_EN       7
`define TCC_BIT_FAST_CLR       4
`define TCC_BIT_PREC_MODE      3
`define TCC_BIT_OVF_IRQ_EN     7
`define TCC_BIT_OVF_FLAG       7
`define TCC_PRESC_MSB          2
`define TCC_PRESC_LSB          0

// Reset values
`define TCC_RST_BYTE           8'h00
`define TCC_RST_NIBBLE         4'h0
`define TCC_RST_PRESC          3'h0
`define TCC_RST_DIV            8'h00

// Bus answers and widths
`define TCC_RESP_OKAY          2'h0
`define TCC_RESP_SLVERR        2'h2
`define TCC_ZERO_WORD          32'h0000_0000
`define TCC_ZERO_24            24'h00_0000
`define TCC_DIV_ONE            8'h01

// Output action codes, mode bit then level bit
`define TCC_ACT_NONE           2'h0
`define TCC_ACT_TOGGLE         2'h1
`define TCC_ACT_LOW            2'h2
`define TCC_ACT_HIGH           2'h3

`endif

// >>> tb/tcc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_ctrl_chk (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  compare_match,
  input wire logic [3:0]  pin_disconnect_bit,
  input wire logic [3:0]  compare_output,
  input wire logic [3:0]  channel_pin_oe
);
  // One domain: shared clock and reset for every property
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////
  // Channel pins
  chk_pin_disc: assert property (
    $stable(pin_disconnect_bit) |-> (channel_pin_oe & pin_disconnect_bit) == 4'h0)
    else $error("pin driven while disconnected");
  // A channel's output moves only after its own compare hit
  chk_cmp_cause: assert property (
    ((compare_output ^ $past(compare_output)) & ~$past(compare_match)) == 4'h0)
    else $error("compare output moved without a match");

  ////////////////////////////////////////////////////////////////////
  // Register bus answers
  // An answer may only go away once the master has taken it
  chk_bvalid_hold: assert property (
    $fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (
    $fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped early");
  chk_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  // Registers are one byte wide, so the upper lanes stay quiet
  chk_rdata_top: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted while busy");
endmodule
`default_nettype wire

// >>> tb/tcc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  input  wire logic       clock,
  input  wire logic [3:0] compare_output,
  input  wire logic [3:0] channel_pin_oe,
  output wire logic [3:0] channel_pin_in
);
  logic [3:0] far_level;

  // Far side yields each pin wherever the channel drives it
  assign channel_pin_in = (channel_pin_oe & compare_output) |
                          (~channel_pin_oe & far_level);

  initial far_level = 4'h0;

  // Lines move just after an edge and are held far longer than
  // two bus clocks, the shortest pulse the capture logic sees
  task automatic set_level(input logic [3:0] v);
    @(posedge clock);
    far_level <= v;
  endtask
endmodule
`default_nettype wire

// >>> tb/tcc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_ctrl_bench;
  logic        clock;
  logic        reset_n;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        counter_wrap;
  logic        counter_access;
  logic [3:0]  compare_match;
  logic [3:0]  channel_is_compare;
  logic [3:0]  value_read;
  logic [3:0]  value_write;
  logic [3:0]  pin_disconnect_bit;
  wire  [3:0]  channel_pin_in;
  logic [3:0]  compare_output;
  logic [3:0]  channel_pin_oe;
  logic        timer_run;
  logic        prescale_tick;
  logic [3:0]  capture_event;
  logic [3:0]  channel_irq;
  logic        overflow_irq;
  logic [1:0]  last_bresp;
  logic [7:0]  precision_divisor;
  int          failures;
  int          checks_done;

  tcc_ctrl tcc_ctrl_inst (
    .clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .counter_wrap, .counter_access,
    .compare_match, .channel_is_compare, .value_read, .value_write,
    .pin_disconnect_bit, .precision_divisor, .channel_pin_in,
    .compare_output, .channel_pin_oe, .timer_run, .prescale_tick,
    .capture_event, .channel_irq, .overflow_irq);

  tcc_pin_model tcc_pin_model_inst (
    .clock, .compare_output, .channel_pin_oe, .channel_pin_in);

  // 200 MHz bus clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic timeout;
    failures++;
    print_verdict();
  endtask

  ////////////////////////////////////////////////////////////////////
  // Bus master; bready and rready stay high, so every answer is
  // taken at the first edge at which it stands
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    last_bresp = s_axi_bresp;
    if (n >= 100) timeout();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 100) timeout();
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] v);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(nm, {24'h00_0000, v}, d);
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!prescale_tick && n < 300);
    if (n >= 300) timeout();
  endtask

  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    for (int a = 8'h18; a <= 8'h3c; a += 4)
      rchk("reset value", 8'(a), 8'h00);
    rd(8'h40, d, r);
    check("unmapped resp", {30'h0, `TCC_RESP_SLVERR}, {30'h0, r});
    wr(8'h40, 8'hff);
    check("unmapped wresp", {30'h0, `TCC_RESP_SLVERR}, {30'h0, last_bresp});
  endtask

  task automatic t_unimpl;
    wr(8'h18, 8'h90);
    @(posedge clock);
    check("timer run", 1, timer_run);
    wr(8'h20, 8'hff);
    rchk("out ctrl hi", 8'h20, 8'h00);
    wr(8'h28, 8'hff);
    rchk("edge ctrl hi", 8'h28, 8'h00);
    wr(8'h30, 8'hff);
    rchk("irq enable", 8'h30, 8'h0f);
    wr(8'h30, 8'h00);
  endtask

  // Toggle, low, high, none on channels 0 to 3
  task automatic t_compare;
    channel_is_compare <= 4'hf;
    wr(8'h24, 8'h39);
    repeat (2) @(posedge clock);
    check("pin oe", 4'h7, channel_pin_oe);
    for (int i = 0; i < 2; i++) begin
      compare_match <= 4'hf;
      @(posedge clock);
      compare_match <= 4'h0;
      repeat (2) @(posedge clock);
      check("cmp out", i ? 4'h4 : 4'h5, compare_output);
    end
    rchk("flags", 8'h38, 8'h0f);
    pin_disconnect_bit <= 4'h4;
    repeat (3) @(posedge clock);
    check("pin oe disc", 4'h3, channel_pin_oe);
    pin_disconnect_bit <= 4'h0;
  endtask

  task automatic t_flags;
    wr(8'h30, 8'h05);
    repeat (2) @(posedge clock);
    check("ch irq", 4'h5, channel_irq);
    wr(8'h38, 8'h00);
    rchk("flags w0", 8'h38, 8'h0f);
    wr(8'h38, 8'h01);
    rchk("flags w1c", 8'h38, 8'h0e);
    value_write <= 4'h2;
    @(posedge clock);
    value_write <= 4'h0;
    rchk("fast clear", 8'h38, 8'h0c);
    // Same-cycle set and fast clear on channel 2
    value_write <= 4'h4;
    compare_match <= 4'h4;
    @(posedge clock);
    value_write <= 4'h0;
    compare_match <= 4'h0;
    rchk("set wins", 8'h38, 8'h0c);
    wr(8'h38, 8'h0f);
    repeat (2) @(posedge clock);
    check("ch irq off", 4'h0, channel_irq);
  endtask

  task automatic t_overflow;
    counter_wrap <= 1'b1;
    @(posedge clock);
    counter_wrap <= 1'b0;
    rchk("ovf set", 8'h3c, 8'h80);
    check("ovf irq off", 0, overflow_irq);
    wr(8'h34, 8'h80);
    repeat (2) @(posedge clock);
    check("ovf irq on", 1, overflow_irq);
    counter_access <= 1'b1;
    @(posedge clock);
    counter_access <= 1'b0;
    rchk("ovf fast", 8'h3c, 8'h00);
    counter_wrap <= 1'b1;
    compare_match <= 4'h1;
    @(posedge clock);
    counter_wrap <= 1'b0;
    compare_match <= 4'h0;
    // Write-one clears are refused while the timer is stopped
    wr(8'h18, 8'h10);
    wr(8'h3c, 8'h80);
    wr(8'h38, 8'h01);
    check("timer stop", 0, timer_run);
    rchk("ovf kept", 8'h3c, 8'h80);
    rchk("flag kept", 8'h38, 8'h01);
    wr(8'h18, 8'h90);
    wr(8'h3c, 8'h80);
    rchk("ovf w1c", 8'h3c, 8'h00);
  endtask

  // Gathers capture pulses; each stands for one cycle only
  task automatic watch_cap(output logic [3:0] s);
    s = 4'h0;
    repeat (8) begin
      @(posedge clock);
      s = s | capture_event;
    end
  endtask

  // Rising, falling, both, off on channels 0 to 3
  task automatic t_capture;
    logic [3:0] seen;
    channel_is_compare <= 4'h0;
    wr(8'h24, 8'h00);
    // Released compare pins settle before any edge is armed
    repeat (8) @(posedge clock);
    wr(8'h38, 8'h0f);
    wr(8'h2c, 8'h39);
    tcc_pin_model_inst.set_level(4'hf);
    watch_cap(seen);
    check("cap event rise", 4'h5, seen);
    rchk("cap rise", 8'h38, 8'h05);
    wr(8'h38, 8'h0f);
    tcc_pin_model_inst.set_level(4'h0);
    watch_cap(seen);
    check("cap event fall", 4'h6, seen);
    rchk("cap fall", 8'h38, 8'h06);
  endtask

  // Divisor is measured only after the switch has had a boundary
  task automatic t_prescale;
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(8'h34, 8'(c));
      repeat (2) wait_tick(n);
      wait_tick(n);
      check("tick period", 32'(1 << c), 32'(n));
    end
  endtask

  // Mode bit is write-once, so precision needs a fresh reset
  task automatic t_precision;
    int n;
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    rchk("flags reset", 8'h38, 8'h00);
    precision_divisor <= 8'h04;
    wr(8'h18, 8'h88);
    wr(8'h18, 8'h80);
    rchk("prec locked", 8'h18, 8'h88);
    repeat (2) wait_tick(n);
    check("prec period", 5, n);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    reset_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_arvalid, counter_wrap, counter_access} = '0;
    s_axi_wstrb = 4'hf;
    {compare_match, channel_is_compare, value_read} = '0;
    {value_write, pin_disconnect_bit, precision_divisor} = '0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_unimpl();
    t_compare();
    t_flags();
    t_overflow();
    t_capture();
    t_prescale();
    t_precision();
    print_verdict();
  end
endmodule

bind tcc_ctrl tcc_ctrl_chk tcc_ctrl_chk_inst (
  .clock, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .compare_match, .pin_disconnect_bit, .compare_output,
  .channel_pin_oe);
`default_nettype wire
